//--- pkg/bfs_pkg.sv
// Purpose: constants shared by the fault status bank and its bus slave
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: printed offsets are word indices; byte address is four times the index
package bfs_pkg;

  // ----------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 17;
  localparam int IDX_W = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_OPEN_WIRE_STATUS = 15'h7F27;
  localparam logic [IDX_W-1:0] IDX_SWITCH_DRIVER_STATUS = 15'h7F2A;
  localparam logic [IDX_W-1:0] IDX_DIAGNOSTIC_STATUS = 15'h7F2B;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 15'h7F40;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 15'h7F41;

  // ----------------------------------------------------------------------
  // open_wire_status layout
  // ----------------------------------------------------------------------
  localparam int NUM_TAPS = 10;
  localparam int OW_W = 24;
  localparam int OW_TAP_LSB = 0;
  localparam int OW_SCAN_BIT = 23;
  localparam logic [OW_W-1:0] OW_RESET = 24'h000000;

  // ----------------------------------------------------------------------
  // switch_driver_status layout
  // ----------------------------------------------------------------------
  localparam int SW_W = 8;
  localparam int SW_PUMP_BIT = 7;
  localparam int SW_MOVING_LSB = 4;
  localparam int SW_TIMEOUT_BIT = 3;
  localparam int SW_ON_LSB = 0;
  localparam logic [SW_W-1:0] SW_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // diagnostic_status layout
  // ----------------------------------------------------------------------
  localparam int DG_W = 8;
  localparam int DG_CRC_FAIL_BIT = 6;
  localparam int DG_CRC_DONE_BIT = 5;
  localparam int DG_SUPPLY_LSB = 2;
  localparam int DG_OV_BIT = 1;
  localparam int DG_UV_BIT = 0;
  localparam logic [DG_W-1:0] DG_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // interrupt status and mask layout
  // ----------------------------------------------------------------------
  localparam int IRQ_W = 6;
  localparam int IRQ_OPEN_WIRE = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_CRC_DONE = 2;
  localparam int IRQ_CRC_FAIL = 3;
  localparam int IRQ_SUPPLY = 4;
  localparam int IRQ_SELFTEST = 5;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 6'h00;

endpackage

//--- pkg/bfs_reg_if.sv
// Purpose: register access carrier between the bus slave and the status bank
// Assumes: single clock, requests are one-cycle pulses
// Notes: read data and hit flags are combinational from the bank
`timescale 1ns/100ps
interface bfs_reg_if;
  import bfs_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;
  logic rd_hit;
  modport bus (output wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx, input wr_hit, rd_data, rd_hit);
  modport bank (input wr_en, wr_idx, wr_data, wr_strb, rd_en, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface

//--- src/bfs_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the fault status bank
// Assumes: one write and one read in flight at most
// Notes: address and data of a write may arrive in either order
`timescale 1ns/100ps
module bfs_axil_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [bfs_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [bfs_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read
  input wire logic [bfs_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [bfs_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  bfs_reg_if.bus regs
);
  import bfs_pkg::*;

  logic aw_held_reg;
  logic w_held_reg;
  logic [IDX_W-1:0] aw_idx_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // ----------------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------------
  // holding both halves before acting keeps the order of arrival irrelevant
  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign regs.wr_en = aw_held_reg && w_held_reg;
  assign regs.wr_idx = aw_idx_reg;
  assign regs.wr_data = w_data_reg;
  assign regs.wr_strb = w_strb_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= '0;
    end else if (awvalid && awready) begin
      aw_held_reg <= 1'b1;
      aw_idx_reg <= awaddr[ADDR_W-1:2];
    end else if (regs.wr_en) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (regs.wr_en) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (regs.wr_en) begin
      bvalid <= 1'b1;
      bresp <= regs.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  assign arready = !rvalid;
  assign regs.rd_en = arvalid && arready;
  assign regs.rd_idx = araddr[ADDR_W-1:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (regs.rd_en) begin
      rvalid <= 1'b1;
      rdata <= regs.rd_hit ? regs.rd_data : '0;
      rresp <= regs.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

//--- src/bfs_fault_status_bank.sv
// Purpose: read-only fault and state status bank of a battery monitor
// Assumes: detection inputs are asynchronous levels; single 50 MHz clock
// Notes: status words follow the inputs three cycles late; interrupts are extra
//
// Notes on behaviour
// R1 - Each cell tap has an open-wire flag at the bit equal to its tap number, 1 meaning open.
// R2 - Tap 0, the negative end of the first cell, reports in bit 0 of the open-wire word.
// R3 - Bit 23 of the open-wire word is 1 while periodic open-wire scanning runs, else 0.
// R4 - Bit 7 of the switch word is 1 while the charge pump runs and 0 when it is stopped.
// R5 - Bits 6, 5, 4 show the standby-discharge, discharge and charge drivers moving, 0 once settled.
// R6 - Bit 3 of the switch word is 1 when a switch turn-on timeout is detected, else 0.
// R7 - Bits 2, 1, 0 show the standby-discharge, discharge and charge switches on.
// R8 - Diagnostic bit 5 shows the memory CRC check done and bit 6 a CRC failure.
// R9 - Diagnostic bits 4, 3, 2 flag core supply, auxiliary rail and regulator input failures.
// R10 - Diagnostic bit 1 flags a failed over-voltage and bit 0 a failed under-voltage self-test.
// R11 - All status fields are read-only, reset to zero, and ignore software writes.
`timescale 1ns/100ps
module bfs_fault_status_bank (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [bfs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [bfs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [bfs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [bfs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // open-wire detection
  input wire logic [bfs_pkg::NUM_TAPS-1:0] tap_broken_wire_flag,
  input wire logic broken_wire_scan_active,
  // switch drivers, bit order standby-discharge, discharge, charge
  input wire logic charge_pump_running,
  input wire logic [2:0] switch_driver_moving,
  input wire logic switch_turn_on_timeout,
  input wire logic [2:0] switch_conducting,
  // diagnostics
  input wire logic crc_check_done,
  input wire logic crc_check_fail,
  input wire logic core_supply_fail,
  input wire logic aux_supply_rail_fail,
  input wire logic regulator_input_fail,
  input wire logic overvoltage_selftest_fail,
  input wire logic undervoltage_selftest_fail,
  // interrupt
  output logic irq
);
  import bfs_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  bfs_reg_if reg_if ();

  logic [NUM_TAPS-1:0] tap_meta_reg;
  logic [NUM_TAPS-1:0] tap_sync_reg;
  logic [SW_W-1:0] sw_meta_reg;
  logic [SW_W-1:0] sw_sync_reg;
  logic [DG_W-1:0] dg_meta_reg;
  logic [DG_W-1:0] dg_sync_reg;
  logic scan_meta_reg;
  logic scan_sync_reg;

  logic [OW_W-1:0] open_wire_status_reg;
  logic [OW_W-1:0] open_wire_status_next;
  logic [SW_W-1:0] switch_driver_status_reg;
  logic [SW_W-1:0] switch_driver_status_next;
  logic [DG_W-1:0] diagnostic_status_reg;
  logic [DG_W-1:0] diagnostic_status_next;

  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;
  logic irq_reg;

  logic [SW_W-1:0] sw_raw;
  logic [DG_W-1:0] dg_raw;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // used for both read and write so the two answers never disagree
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = (idx == IDX_OPEN_WIRE_STATUS) || (idx == IDX_SWITCH_DRIVER_STATUS) ||
                (idx == IDX_DIAGNOSTIC_STATUS) || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
  endfunction

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  // prot inputs are accepted and ignored: all registers are open to any access
  bfs_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .regs(reg_if.bus)
  );

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // detection flags come from analog comparators and slow state machines
  always_comb begin
    sw_raw = '0;
    sw_raw[SW_PUMP_BIT] = charge_pump_running;
    sw_raw[SW_MOVING_LSB +: 3] = switch_driver_moving;
    sw_raw[SW_TIMEOUT_BIT] = switch_turn_on_timeout;
    sw_raw[SW_ON_LSB +: 3] = switch_conducting;
  end

  always_comb begin
    dg_raw = '0;
    dg_raw[DG_CRC_FAIL_BIT] = crc_check_fail;
    dg_raw[DG_CRC_DONE_BIT] = crc_check_done;
    dg_raw[DG_SUPPLY_LSB +: 3] = {core_supply_fail, aux_supply_rail_fail, regulator_input_fail};
    dg_raw[DG_OV_BIT] = overvoltage_selftest_fail;
    dg_raw[DG_UV_BIT] = undervoltage_selftest_fail;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tap_meta_reg <= '0;
      tap_sync_reg <= '0;
      scan_meta_reg <= 1'b0;
      scan_sync_reg <= 1'b0;
      sw_meta_reg <= '0;
      sw_sync_reg <= '0;
      dg_meta_reg <= '0;
      dg_sync_reg <= '0;
    end else begin
      tap_meta_reg <= tap_broken_wire_flag;
      tap_sync_reg <= tap_meta_reg;
      scan_meta_reg <= broken_wire_scan_active;
      scan_sync_reg <= scan_meta_reg;
      sw_meta_reg <= sw_raw;
      sw_sync_reg <= sw_meta_reg;
      dg_meta_reg <= dg_raw;
      dg_sync_reg <= dg_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // status words
  // ----------------------------------------------------------------------
  always_comb begin
    open_wire_status_next = OW_RESET;
    open_wire_status_next[OW_TAP_LSB +: NUM_TAPS] = tap_sync_reg; // [R1] [R2]
    open_wire_status_next[OW_SCAN_BIT] = scan_sync_reg; // [R3]
  end

  always_comb begin
    switch_driver_status_next = SW_RESET;
    switch_driver_status_next[SW_PUMP_BIT] = sw_sync_reg[SW_PUMP_BIT]; // [R4]
    switch_driver_status_next[SW_MOVING_LSB +: 3] = sw_sync_reg[SW_MOVING_LSB +: 3]; // [R5]
    switch_driver_status_next[SW_TIMEOUT_BIT] = sw_sync_reg[SW_TIMEOUT_BIT]; // [R6]
    switch_driver_status_next[SW_ON_LSB +: 3] = sw_sync_reg[SW_ON_LSB +: 3]; // [R7]
  end

  always_comb begin
    diagnostic_status_next = DG_RESET;
    diagnostic_status_next[DG_CRC_FAIL_BIT] = dg_sync_reg[DG_CRC_FAIL_BIT]; // [R8]
    diagnostic_status_next[DG_CRC_DONE_BIT] = dg_sync_reg[DG_CRC_DONE_BIT]; // [R8]
    diagnostic_status_next[DG_SUPPLY_LSB +: 3] = dg_sync_reg[DG_SUPPLY_LSB +: 3]; // [R9]
    diagnostic_status_next[DG_OV_BIT] = dg_sync_reg[DG_OV_BIT]; // [R10]
    diagnostic_status_next[DG_UV_BIT] = dg_sync_reg[DG_UV_BIT]; // [R10]
  end

  // no write term here: software can only look at these words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_wire_status_reg <= OW_RESET; // [R11]
      switch_driver_status_reg <= SW_RESET; // [R11]
      diagnostic_status_reg <= DG_RESET; // [R11]
    end else begin
      open_wire_status_reg <= open_wire_status_next;
      switch_driver_status_reg <= switch_driver_status_next;
      diagnostic_status_reg <= diagnostic_status_next;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------------
  // rising edges of fault flags, so a stuck fault interrupts once per onset
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_OPEN_WIRE] = |(open_wire_status_next[OW_TAP_LSB +: NUM_TAPS] &
                                 ~open_wire_status_reg[OW_TAP_LSB +: NUM_TAPS]);
    irq_event[IRQ_TIMEOUT] = switch_driver_status_next[SW_TIMEOUT_BIT] &
                             ~switch_driver_status_reg[SW_TIMEOUT_BIT];
    irq_event[IRQ_CRC_DONE] = diagnostic_status_next[DG_CRC_DONE_BIT] &
                              ~diagnostic_status_reg[DG_CRC_DONE_BIT];
    irq_event[IRQ_CRC_FAIL] = diagnostic_status_next[DG_CRC_FAIL_BIT] &
                              ~diagnostic_status_reg[DG_CRC_FAIL_BIT];
    irq_event[IRQ_SUPPLY] = |(diagnostic_status_next[DG_SUPPLY_LSB +: 3] &
                              ~diagnostic_status_reg[DG_SUPPLY_LSB +: 3]);
    irq_event[IRQ_SELFTEST] = |(diagnostic_status_next[DG_OV_BIT:DG_UV_BIT] &
                                ~diagnostic_status_reg[DG_OV_BIT:DG_UV_BIT]);
  end

  assign irq_clear = (reg_if.wr_en && reg_if.wr_idx == IDX_IRQ_STATUS && reg_if.wr_strb[0]) ?
                     reg_if.wr_data[IRQ_W-1:0] : '0;

  // set beats clear so an event in the clearing cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_irq_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          irq_status_reg[gi] <= IRQ_RESET[gi];
        end else if (irq_event[gi]) begin
          irq_status_reg[gi] <= 1'b1;
        end else if (irq_clear[gi]) begin
          irq_status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= IRQ_RESET;
    end else if (reg_if.wr_en && reg_if.wr_idx == IDX_IRQ_MASK && reg_if.wr_strb[0]) begin
      irq_mask_reg <= reg_if.wr_data[IRQ_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  assign irq = irq_reg;

  // ----------------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------------
  // writes to the status words are answered okay and dropped
  assign reg_if.wr_hit = is_mapped(reg_if.wr_idx); // [R11]
  assign reg_if.rd_hit = is_mapped(reg_if.rd_idx);

  always_comb begin
    reg_if.rd_data = '0;
    case (reg_if.rd_idx)
      IDX_OPEN_WIRE_STATUS: begin
        reg_if.rd_data[OW_W-1:0] = open_wire_status_reg;
      end
      IDX_SWITCH_DRIVER_STATUS: begin
        reg_if.rd_data[SW_W-1:0] = switch_driver_status_reg;
      end
      IDX_DIAGNOSTIC_STATUS: begin
        reg_if.rd_data[DG_W-1:0] = diagnostic_status_reg;
      end
      IDX_IRQ_STATUS: begin
        reg_if.rd_data[IRQ_W-1:0] = irq_status_reg;
      end
      IDX_IRQ_MASK: begin
        reg_if.rd_data[IRQ_W-1:0] = irq_mask_reg;
      end
      default: begin
        reg_if.rd_data = '0;
      end
    endcase
  end

endmodule

//--- tb/bfs_status_props.sv
// Purpose: port-level properties of the fault status bank
// Assumes: single clock, synchronous active-low reset
// Notes: status reads are judged only once the inputs have settled
`timescale 1ns/100ps
module bfs_status_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic [bfs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [bfs_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic irq,
  // status sources
  input wire logic [bfs_pkg::NUM_TAPS-1:0] tap_broken_wire_flag,
  input wire logic broken_wire_scan_active,
  input wire logic charge_pump_running,
  input wire logic [2:0] switch_driver_moving,
  input wire logic switch_turn_on_timeout,
  input wire logic [2:0] switch_conducting,
  input wire logic crc_check_done,
  input wire logic crc_check_fail,
  input wire logic core_supply_fail,
  input wire logic aux_supply_rail_fail,
  input wire logic regulator_input_fail,
  input wire logic overvoltage_selftest_fail,
  input wire logic undervoltage_selftest_fail
);
  import bfs_pkg::*;
  logic [25:0] in_now;
  logic [25:0] in_reg;
  logic [2:0] stable_reg;
  logic [IDX_W-1:0] ar_idx;
  logic ar_take;
  // same order as the bench: diag bits, switch word, scan, taps
  assign in_now = {crc_check_fail, crc_check_done, core_supply_fail, aux_supply_rail_fail, regulator_input_fail,
    overvoltage_selftest_fail, undervoltage_selftest_fail, charge_pump_running, switch_driver_moving,
    switch_turn_on_timeout, switch_conducting, broken_wire_scan_active, tap_broken_wire_flag};
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];
  // the path is three flops deep, so a read counts only after four quiet edges
  assign ar_take = s_axi_arvalid && s_axi_arready && (stable_reg > 3'h3);
  always_ff @(posedge aclk) begin
    in_reg <= in_now;
    if (!aresetn || in_now != in_reg) begin
      stable_reg <= 3'h0;
    end else if (stable_reg != 3'h7) begin
      stable_reg <= stable_reg + 3'h1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_OW_TAPS: assert property (ar_take && ar_idx == IDX_OPEN_WIRE_STATUS |=> s_axi_rdata[9:0] == in_reg[9:0])
    else $error("tap flags wrong");
  AST_OW_SCAN: assert property (ar_take && ar_idx == IDX_OPEN_WIRE_STATUS |=> s_axi_rdata[23] == in_reg[10])
    else $error("scan flag wrong");
  AST_SW_WORD: assert property (ar_take && ar_idx == IDX_SWITCH_DRIVER_STATUS |=> s_axi_rdata == {24'h0, in_reg[18:11]})
    else $error("switch word wrong");
  AST_DG_CRC: assert property (ar_take && ar_idx == IDX_DIAGNOSTIC_STATUS |=> s_axi_rdata[6:5] == in_reg[25:24])
    else $error("crc flags wrong");
  AST_DG_SUPPLY: assert property (ar_take && ar_idx == IDX_DIAGNOSTIC_STATUS |=> s_axi_rdata[4:2] == in_reg[23:21])
    else $error("supply flags wrong");
  AST_DG_SELFTEST: assert property (ar_take && ar_idx == IDX_DIAGNOSTIC_STATUS |=> s_axi_rdata[1:0] == in_reg[20:19])
    else $error("self-test flags wrong");
  AST_RESET_CLEAR: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && s_axi_rdata == 32'h0)
    else $error("outputs not cleared by reset");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule
bind bfs_fault_status_bank bfs_status_props props_i (.*);

//--- tb/tb.sv
// Purpose: self-checking bench for the fault status bank
// Assumes: 50 MHz clock; the tasks below act as AXI4-Lite master
// Notes: input levels are random from a fixed seed, corner cases first
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import bfs_pkg::*;
  localparam logic [ADDR_W-1:0] A_IS = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] A_IM = {IDX_IRQ_MASK, 2'h0};
  localparam logic [ADDR_W-1:0] RO [3] = '{{IDX_OPEN_WIRE_STATUS, 2'h0}, {IDX_SWITCH_DRIVER_STATUS, 2'h0},
    {IDX_DIAGNOSTIC_STATUS, 2'h0}};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, scan, pump, tout;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, v, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [9:0] taps;
  logic [2:0] mov, con;
  logic [6:0] dgi;
  int failures, tests_run, cyc;
  bfs_fault_status_bank uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tap_broken_wire_flag(taps), .broken_wire_scan_active(scan), .charge_pump_running(pump),
    .switch_driver_moving(mov), .switch_turn_on_timeout(tout), .switch_conducting(con),
    .crc_check_fail(dgi[6]), .crc_check_done(dgi[5]), .core_supply_fail(dgi[4]), .aux_supply_rail_fail(dgi[3]),
    .regulator_input_fail(dgi[2]), .overvoltage_selftest_fail(dgi[1]), .undervoltage_selftest_fail(dgi[0]),
    .irq(irq)
  );
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ----------------------------------------------------------------------
  // bus tasks; rready is raised late so the slave has to hold its read answer; bready rises with bvalid
  // ----------------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dat, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (!awvalid && !wvalid) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] dat, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (!arvalid) rready <= 1'b1;
    end while (!(rvalid && rready));
    dat = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic [31:0] exp_word(input int k);
    case (k)
      0: return {8'h00, scan, 13'h0000, taps};
      1: return {24'h000000, pump, mov, tout, con};
      default: return {25'h0000000, dgi};
    endcase
  endfunction
  task automatic set_in(input logic [31:0] s);
    @(posedge aclk);
    {scan, taps} <= s[10:0];
    {pump, mov, tout, con} <= s[18:11];
    dgi <= s[25:19];
  endtask
  task automatic chk_status();
    logic [31:0] e [3];
    logic [31:0] q [3];
    repeat (5) @(posedge aclk);
    for (int k = 0; k < 3; k++) begin
      e[k] = exp_word(k);
      rd(RO[k], q[k], r);
      `CHK("rresp", RESP_OKAY, r)
      `CHK("word", e[k], q[k])
    end
    `CHK("taps", e[0][9:0], q[0][9:0])
    `CHK("tap0", e[0][0], q[0][0])
    `CHK("scan", e[0][23], q[0][23])
    `CHK("pump", e[1][7], q[1][7])
    `CHK("moving", e[1][6:4], q[1][6:4])
    `CHK("timeout", e[1][3], q[1][3])
    `CHK("on", e[1][2:0], q[1][2:0])
    `CHK("crc", e[2][6:5], q[2][6:5])
    `CHK("supply", e[2][4:2], q[2][4:2])
    `CHK("selftest", e[2][1:0], q[2][1:0])
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 5000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(83));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, scan, pump, tout} = 9'h000;
    {awaddr, araddr, wdata, wstrb, taps, mov, con, dgi} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk_status();
    rd(A_IM, d, r);
    `CHK("irq_mask_reset", 32'h0, d)
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      case (i)
        0: v = 32'h0000_0001;
        1: v = 32'h0000_0200;
        2: v = 32'h0000_0400;
        3: v = 32'h03FF_FFFF;
        default: v = $urandom;
      endcase
      set_in(v);
      // a write to a status word must be accepted and leave it untouched
      wr(RO[i % 3], $urandom, RESP_OKAY);
      chk_status();
      $display("test status %0d done", i);
    end
    wr(17'h00010, $urandom, RESP_SLVERR);
    rd(17'h00010, d, r);
    `CHK("unmapped_resp", RESP_SLVERR, r)
    `CHK("unmapped_data", 32'h0, d)
    $display("test unmapped done");
    set_in(32'h0);
    repeat (6) @(posedge aclk);
    wr(A_IS, 32'h3F, RESP_OKAY);
    wr(A_IM, 32'h02, RESP_OKAY);
    `CHK("irq_idle", 1'b0, irq)
    set_in(32'h0000_4000);
    repeat (6) @(posedge aclk);
    `CHK("irq_raised", 1'b1, irq)
    set_in(32'h0100_0000);
    repeat (6) @(posedge aclk);
    rd(A_IS, d, r);
    `CHK("irq_status", 32'h06, d)
    wr(A_IS, 32'h02, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("irq_cleared", 1'b0, irq)
    rd(A_IS, d, r);
    `CHK("irq_masked_kept", 32'h04, d)
    wstrb <= 4'hE;
    wr(A_IM, 32'h3F, RESP_OKAY);
    wstrb <= 4'hF;
    rd(A_IM, d, r);
    `CHK("mask_lane0_off", 32'h02, d)
    $display("test interrupt done");
    end_sim();
  end
endmodule
